// ==== hw/shift_flag_pkg.sv ====
// shared constants, opcodes and carrier types of the shift, rotate and flag unit
package shift_flag_pkg;
    localparam int NUM_WORK_REGS = 16;
    localparam int REG_IDX_W     = 4;
    localparam int ADDR_W        = 8;

    // byte addresses of the software-visible words
    localparam logic [ADDR_W-1:0] ADDR_COMMAND    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SELECT     = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_WORK_DATA  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_UNIT_STATE = 8'h10;

    // command word field positions
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_BIT_LSB = 12;

    // status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] WORK_RESET   = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_NOP                    = 4'h0,
        OP_LOGICAL_RIGHT_SHIFT    = 4'h1,
        OP_ROTATE_LEFT_CARRY      = 4'h2,
        OP_ROTATE_RIGHT_CARRY     = 4'h3,
        OP_ARITHMETIC_RIGHT_SHIFT = 4'h4,
        OP_BIT_STORE_TO_TRANSFER  = 4'h5,
        OP_BIT_LOAD_FROM_TRANSFER = 4'h6,
        OP_SET_OVERFLOW_FLAG      = 4'h7,
        OP_CLEAR_OVERFLOW_FLAG    = 4'h8,
        OP_SET_SIGN_FLAG          = 4'h9,
        OP_CLEAR_SIGN_FLAG        = 4'ha,
        OP_SET_HALF_CARRY         = 4'hb,
        OP_CLEAR_HALF_CARRY       = 4'hc,
        OP_SLEEP                  = 4'hd,
        OP_WATCHDOG_RESTART       = 4'he
    } unit_op_t;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       zero;
        logic       negative;
        logic       overflow;
    } shift_out_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] result;
        logic       regWrite;
    } bit_out_t;

    typedef struct packed {
        logic                               awHeld;
        logic [ADDR_W-1:0]                  awAddr;
        logic                               wHeld;
        logic [31:0]                        wData;
        logic [3:0]                         wStrb;
        logic                               awReady;
        logic                               wReady;
        logic                               bValid;
        logic [1:0]                         bResp;
        logic                               arReady;
        logic                               rValid;
        logic [31:0]                        rData;
        logic [1:0]                         rResp;
        logic                               pending;
        logic [3:0]                         pendOp;
        logic [REG_IDX_W-1:0]               pendReg;
        logic [2:0]                         pendBit;
        logic [REG_IDX_W-1:0]               select;
        logic [7:0]                         flags;
        logic [NUM_WORK_REGS-1:0][7:0]      regs;
        logic                               sleepReq;
        logic                               wdRestart;
    } unit_state_t;
endpackage

// ==== hw/shift_rotate_core.sv ====
// combinational shift and rotate datapath with its flag results
`timescale 1ns/1ns
module shift_rotate_core
    import shift_flag_pkg::*;
(
    input  wire logic [3:0] op,
    input  wire logic [7:0] operand,
    input  wire logic       carryIn,
    output shift_out_t      shOut
);
    logic [7:0] res;
    logic       cy;

    always_comb begin
        res = operand;
        cy  = carryIn;
        unique case (op)
            OP_LOGICAL_RIGHT_SHIFT: begin
                res = {1'h0, operand[7:1]};
                cy  = operand[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                res = {operand[6:0], carryIn};
                cy  = operand[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                res = {carryIn, operand[7:1]};
                cy  = operand[0];
            end
            OP_ARITHMETIC_RIGHT_SHIFT: begin
                res = {operand[7], operand[7:1]};
                cy  = operand[0];
            end
            default: begin
                res = operand;
                cy  = carryIn;
            end
        endcase
        shOut.result   = res;
        shOut.carry    = cy;
        shOut.zero     = (res == 8'h00);
        shOut.negative = res[7];
        // overflow after a shift is the sign xor the bit shifted out
        shOut.overflow = res[7] ^ cy;
    end
endmodule

// ==== hw/bit_flag_core.sv ====
// combinational bit transfer and single-flag set and clear logic
`timescale 1ns/1ns
module bit_flag_core
    import shift_flag_pkg::*;
(
    input  wire logic [3:0] op,
    input  wire logic [7:0] flagsIn,
    input  wire logic [7:0] operand,
    input  wire logic [2:0] bitIdx,
    output bit_out_t        bitOut
);
    always_comb begin
        bitOut.flags    = flagsIn;
        bitOut.result   = operand;
        bitOut.regWrite = 1'h0;
        unique case (op)
            OP_BIT_STORE_TO_TRANSFER:  bitOut.flags[FLAG_T] = operand[bitIdx];
            OP_BIT_LOAD_FROM_TRANSFER: begin
                bitOut.result[bitIdx] = flagsIn[FLAG_T];
                bitOut.regWrite       = 1'h1;
            end
            OP_SET_OVERFLOW_FLAG:      bitOut.flags[FLAG_V] = 1'h1;
            OP_CLEAR_OVERFLOW_FLAG:    bitOut.flags[FLAG_V] = 1'h0;
            OP_SET_SIGN_FLAG:          bitOut.flags[FLAG_S] = 1'h1;
            OP_CLEAR_SIGN_FLAG:        bitOut.flags[FLAG_S] = 1'h0;
            OP_SET_HALF_CARRY:         bitOut.flags[FLAG_H] = 1'h1;
            OP_CLEAR_HALF_CARRY:       bitOut.flags[FLAG_H] = 1'h0;
            default:                   bitOut.flags = flagsIn;
        endcase
    end
endmodule

// ==== hw/shift_rotate_flag_ops_unit.sv ====
// top of the shift, rotate and flag unit with its AXI4-Lite register slave
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// - logical right shift, bit 7 zero, flags
// - rotate left through carry, flags, one clock
// - rotate right through carry, flags, one clock
// - arithmetic right shift keeps bit 7
// - selected register bit copied to transfer flag
// - transfer flag written into selected bit
// - overflow flag forced to one
// - overflow flag forced to zero
// - sign flag forced to one
// - sign flag forced to zero
// - half carry flag forced to one
// - half carry flag forced to zero
// - sleep takes one clock, requests sleep
// - watchdog restart takes one clock, pulses restart
module shift_rotate_flag_ops_unit
    import shift_flag_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   sleepRequest,
    output logic                   watchdogRestart
);
    unit_state_t st;
    unit_state_t next_st;
    logic [7:0]  srcVal;
    logic        srcBit;
    shift_out_t  shOut;
    bit_out_t    bitOut;

    assign srcVal = st.regs[st.pendReg];
    assign srcBit = srcVal[st.pendBit];

    shift_rotate_core u_shift (
        .op      (st.pendOp),
        .operand (srcVal),
        .carryIn (st.flags[FLAG_C]),
        .shOut   (shOut)
    );

    bit_flag_core u_bits (
        .op      (st.pendOp),
        .flagsIn (st.flags),
        .operand (srcVal),
        .bitIdx  (st.pendBit),
        .bitOut  (bitOut)
    );

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_COMMAND) || (a == ADDR_STATUS) || (a == ADDR_SELECT) ||
               (a == ADDR_WORK_DATA) || (a == ADDR_UNIT_STATE);
    endfunction

    function automatic logic [31:0] readWord(input unit_state_t s, input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            ADDR_STATUS:     w[7:0] = s.flags;
            ADDR_SELECT:     w[REG_IDX_W-1:0] = s.select;
            ADDR_WORK_DATA:  w[7:0] = s.regs[s.select];
            ADDR_UNIT_STATE: w[0] = s.pending;
            default:         w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    always_comb begin
        next_st           = st;
        next_st.sleepReq  = 1'h0;
        next_st.wdRestart = 1'h0;

        // read channel: one outstanding read, data captured at the address handshake
        if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'h0;
        end
        if (st.arReady && s_axi_arvalid) begin
            next_st.rValid = 1'h1;
            next_st.rData  = readWord(st, s_axi_araddr);
            next_st.rResp  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arReady = !next_st.rValid;

        // write channels: address and data may come in either order
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'h0;
        end
        if (st.awReady && s_axi_awvalid) begin
            next_st.awHeld = 1'h1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (st.wReady && s_axi_wvalid) begin
            next_st.wHeld = 1'h1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (next_st.awHeld && next_st.wHeld && !next_st.bValid) begin
            next_st.awHeld = 1'h0;
            next_st.wHeld  = 1'h0;
            next_st.bValid = 1'h1;
            next_st.bResp  = isMapped(next_st.awAddr) ? RESP_OKAY : RESP_SLVERR;
            if (next_st.wStrb[0]) begin
                unique case (next_st.awAddr)
                    ADDR_STATUS:    next_st.flags = next_st.wData[7:0];
                    ADDR_SELECT:    next_st.select = next_st.wData[REG_IDX_W-1:0];
                    ADDR_WORK_DATA: next_st.regs[next_st.select] = next_st.wData[7:0];
                    default:        next_st.flags = next_st.flags;
                endcase
            end
            // a command needs both low lanes so that opcode and operands arrive together
            if (next_st.awAddr == ADDR_COMMAND && next_st.wStrb[1:0] == 2'h3) begin
                next_st.pending = 1'h1;
                next_st.pendOp  = next_st.wData[CMD_OP_LSB +: 4];
                next_st.pendReg = next_st.wData[CMD_REG_LSB +: REG_IDX_W];
                next_st.pendBit = next_st.wData[CMD_BIT_LSB +: 3];
            end
        end
        next_st.awReady = !next_st.awHeld && !next_st.bValid;
        next_st.wReady  = !next_st.wHeld && !next_st.bValid;

        // execute the taken command in the single following clock; it overrides any software write
        if (st.pending) begin
            next_st.pending = 1'h0;
            unique case (st.pendOp)
                OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
                OP_ROTATE_RIGHT_CARRY, OP_ARITHMETIC_RIGHT_SHIFT: begin
                    next_st.regs[st.pendReg]  = shOut.result;
                    next_st.flags[FLAG_C]     = shOut.carry;
                    next_st.flags[FLAG_Z]     = shOut.zero;
                    next_st.flags[FLAG_N]     = shOut.negative;
                    next_st.flags[FLAG_V]     = shOut.overflow;
                end
                OP_SLEEP:            next_st.sleepReq  = 1'h1;
                OP_WATCHDOG_RESTART: next_st.wdRestart = 1'h1;
                default: begin
                    // single-bit flag updates land in the one shared status byte; a bit load writes the selected work register
                    next_st.flags = bitOut.flags;
                    if (bitOut.regWrite) begin
                        next_st.regs[st.pendReg] = bitOut.result;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            // bus, command and pulse state clear; status and work bytes take their reset values
            st       <= '0;
            st.flags <= STATUS_RESET;
            st.regs  <= {NUM_WORK_REGS{WORK_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready   = st.awReady;
    assign s_axi_wready    = st.wReady;
    assign s_axi_bvalid    = st.bValid;
    assign s_axi_bresp     = st.bResp;
    assign s_axi_arready   = st.arReady;
    assign s_axi_rvalid    = st.rValid;
    assign s_axi_rdata     = st.rData;
    assign s_axi_rresp     = st.rResp;
    assign sleepRequest    = st.sleepReq;
    assign watchdogRestart = st.wdRestart;

    localparam logic [7:0] MASK_ZCNV = 8'h0f;

    property p_lsr;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_LOGICAL_RIGHT_SHIFT |=>
            srcVal == {1'h0, $past(srcVal[7:1])} && st.flags[FLAG_C] == $past(srcVal[0]) &&
            !st.flags[FLAG_N] && st.flags[FLAG_V] == st.flags[FLAG_C] &&
            st.flags[FLAG_Z] == (srcVal == 8'h00) && (st.flags & ~MASK_ZCNV) == ($past(st.flags) & ~MASK_ZCNV);
    endproperty
    a_lsr: assert property (p_lsr) else $error("logical right shift result wrong");

    property p_rol;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_ROTATE_LEFT_CARRY |=>
            srcVal == {$past(srcVal[6:0]), $past(st.flags[FLAG_C])} && st.flags[FLAG_C] == $past(srcVal[7]) &&
            st.flags[FLAG_N] == srcVal[7] && st.flags[FLAG_V] == (srcVal[7] ^ st.flags[FLAG_C]) &&
            st.flags[FLAG_Z] == (srcVal == 8'h00);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left through carry wrong");

    property p_ror;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_ROTATE_RIGHT_CARRY |=>
            srcVal == {$past(st.flags[FLAG_C]), $past(srcVal[7:1])} && st.flags[FLAG_C] == $past(srcVal[0]) &&
            st.flags[FLAG_Z] == (srcVal == 8'h00) && st.flags[FLAG_N] == srcVal[7] &&
            st.flags[FLAG_V] == (srcVal[7] ^ st.flags[FLAG_C]);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right through carry wrong");

    property p_asr;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_ARITHMETIC_RIGHT_SHIFT |=>
            srcVal == {$past(srcVal[7]), $past(srcVal[7:1])} && st.flags[FLAG_C] == $past(srcVal[0]) &&
            st.flags[FLAG_N] == $past(srcVal[7]) && st.flags[FLAG_Z] == (srcVal == 8'h00) &&
            st.flags[FLAG_V] == (srcVal[7] ^ st.flags[FLAG_C]);
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic right shift wrong");

    property p_bst;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_BIT_STORE_TO_TRANSFER |=>
            st.flags[FLAG_T] == $past(srcBit) && srcVal == $past(srcVal) &&
            (st.flags ^ $past(st.flags)) inside {8'h00, 8'h40};
    endproperty
    a_bst: assert property (p_bst) else $error("bit store did not copy into transfer flag");

    property p_bld;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_BIT_LOAD_FROM_TRANSFER |=>
            srcBit == $past(st.flags[FLAG_T]) && st.flags == $past(st.flags) &&
            $countones(srcVal ^ $past(srcVal)) <= 1 &&
            ((srcVal ^ $past(srcVal)) & ~(8'h01 << st.pendBit)) == 8'h00;
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrote the wrong bit");

    property p_sev;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_SET_OVERFLOW_FLAG |=> st.flags == ($past(st.flags) | 8'h08);
    endproperty
    a_sev: assert property (p_sev) else $error("overflow set disturbed flags");

    property p_clv;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_CLEAR_OVERFLOW_FLAG |=> st.flags == ($past(st.flags) & 8'hf7);
    endproperty
    a_clv: assert property (p_clv) else $error("overflow clear disturbed flags");

    property p_ses;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_SET_SIGN_FLAG |=> st.flags == ($past(st.flags) | 8'h10);
    endproperty
    a_ses: assert property (p_ses) else $error("sign set disturbed flags");

    property p_cls;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_CLEAR_SIGN_FLAG |=> st.flags == ($past(st.flags) & 8'hef);
    endproperty
    a_cls: assert property (p_cls) else $error("sign clear disturbed flags");

    property p_seh;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_SET_HALF_CARRY |=> st.flags == ($past(st.flags) | 8'h20);
    endproperty
    a_seh: assert property (p_seh) else $error("half carry set disturbed flags");

    property p_clh;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_CLEAR_HALF_CARRY |=> st.flags == ($past(st.flags) & 8'hdf);
    endproperty
    a_clh: assert property (p_clh) else $error("half carry clear disturbed flags");

    property p_sleep;
        @(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_SLEEP |=> sleepRequest && st.flags == $past(st.flags) ##1 !sleepRequest;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep request not a single pulse");

    property p_wdr;
        @(posedge core_clk) disable iff (!nrst)
        $rose(watchdogRestart) |-> $past(st.pending) && $past(st.pendOp) == OP_WATCHDOG_RESTART &&
            st.flags == $past(st.flags) ##1 !watchdogRestart;
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog restart pulse without command");

    property p_one_clock;
        @(posedge core_clk) disable iff (!nrst)
        st.pending |=> !st.pending;
    endproperty
    a_one_clock: assert property (p_one_clock) else $error("command held longer than one clock");

    c_rol: cover property (@(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_ROTATE_LEFT_CARRY && st.flags[FLAG_C] ##1 st.flags[FLAG_C]);
    c_bld: cover property (@(posedge core_clk) disable iff (!nrst)
        st.pending && st.pendOp == OP_BIT_LOAD_FROM_TRANSFER && st.pendBit == 3'h7);
    c_sleep: cover property (@(posedge core_clk) disable iff (!nrst) sleepRequest);
    c_watchdog: cover property (@(posedge core_clk) disable iff (!nrst) watchdogRestart);
    c_write_then_read: cover property (@(posedge core_clk) disable iff (!nrst)
        s_axi_bvalid && s_axi_bready ##[1:8] s_axi_rvalid && s_axi_rready);
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the shift, rotate and flag unit over its register bus
`timescale 1ns/1ns
module tb
    import shift_flag_pkg::*;
;
    logic              core_clk = 1'h0;
    logic              nrst = 1'h0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0]       wdata = '0;
    logic [3:0]        wstrb = '0;
    logic              awready, wready, bvalid, arready, rvalid, sleepRequest, watchdogRestart;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [33:0]       rq[$];
    logic [1:0]        bq[$];
    int                failures = 0, checkCount = 0, sleepSeen = 0, wdSeen = 0;

    shift_rotate_flag_ops_unit i_shift_rotate_flag_ops_unit (
        .core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleepRequest(sleepRequest), .watchdogRestart(watchdogRestart));

    always #50 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        $display("checks %0d, mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // results are compared where the handshake happens, in order of issue
    always @(posedge core_clk) begin
        if (bvalid === 1'h1 && bready === 1'h1)
            check({30'h0, bresp}, {30'h0, bq.pop_front()});
        if (rvalid === 1'h1 && rready === 1'h1) begin
            logic [33:0] e;
            e = rq.pop_front();
            check(rdata, e[31:0]);
            check({30'h0, rresp}, {30'h0, e[33:32]});
        end
        if (sleepRequest === 1'h1) sleepSeen++;
        if (watchdogRestart === 1'h1) wdSeen++;
    end

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit ad, dd;
        ad = 1'h0;
        dd = 1'h0;
        @(posedge core_clk);
        bq.push_back(er);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!(ad && dd)) begin
            @(posedge core_clk);
            if (!ad && awready === 1'h1) begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (!dd && wready === 1'h1) begin
                dd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge core_clk);
        bready <= 1'h0;
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        rq.push_back({er, d});
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge core_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge core_clk); while (rvalid !== 1'h1);
        rready <= 1'h0;
    endtask

    // independent reference of what one command leaves behind: {work register, status}
    function automatic logic [15:0] model(input logic [3:0] op, input logic [7:0] v, input logic [7:0] f,
                                          input logic [2:0] b);
        logic [7:0] r, nf;
        logic       c;
        r  = v;
        nf = f;
        c  = 1'h0;
        case (op)
            4'h1: begin
                r = {1'h0, v[7:1]};
                c = v[0];
            end
            4'h2: begin
                r = {v[6:0], f[FLAG_C]};
                c = v[7];
            end
            4'h3: begin
                r = {f[FLAG_C], v[7:1]};
                c = v[0];
            end
            4'h4: begin
                r = {v[7], v[7:1]};
                c = v[0];
            end
            4'h5: nf[FLAG_T] = v[b];
            4'h6: r[b] = f[FLAG_T];
            4'h7: nf[FLAG_V] = 1'h1;
            4'h8: nf[FLAG_V] = 1'h0;
            4'h9: nf[FLAG_S] = 1'h1;
            4'ha: nf[FLAG_S] = 1'h0;
            4'hb: nf[FLAG_H] = 1'h1;
            4'hc: nf[FLAG_H] = 1'h0;
            default: ;
        endcase
        if (op >= 4'h1 && op <= 4'h4) begin
            nf[FLAG_C] = c;
            nf[FLAG_Z] = (r == 8'h00);
            nf[FLAG_N] = r[7];
            nf[FLAG_V] = r[7] ^ c;
        end
        return {r, nf};
    endfunction

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        completeRun();
    end

    initial begin
        logic [3:0]  idx;
        logic [7:0]  v, f;
        logic [2:0]  b;
        logic [15:0] e;
        void'($urandom(56674));
        repeat (20) @(posedge core_clk);
        nrst <= 1'h1;
        axr(ADDR_STATUS, {24'h0, STATUS_RESET}, RESP_OKAY);
        axr(ADDR_WORK_DATA, {24'h0, WORK_RESET}, RESP_OKAY);
        $display("test reset values done");
        // the sweep includes both no-operation codes, which must leave register and status alone
        for (int op = 0; op <= 15; op++) begin
            repeat (3) begin
                idx = 4'($urandom);
                v = 8'($urandom);
                f = 8'($urandom);
                b = 3'($urandom);
                e = model(4'(op), v, f, b);
                axw(ADDR_SELECT, {28'h0, idx}, 4'hf, RESP_OKAY);
                axw(ADDR_WORK_DATA, {24'h0, v}, 4'hf, RESP_OKAY);
                axw(ADDR_STATUS, {24'h0, f}, 4'hf, RESP_OKAY);
                axw(ADDR_COMMAND, {17'h0, b, idx, 4'h0, 4'(op)}, 4'h3, RESP_OKAY);
                axr(ADDR_WORK_DATA, {24'h0, e[15:8]}, RESP_OKAY);
                axr(ADDR_STATUS, {24'h0, e[7:0]}, RESP_OKAY);
            end
        end
        axr(ADDR_UNIT_STATE, 32'h0, RESP_OKAY);
        check(32'(sleepSeen), 32'h3);
        check(32'(wdSeen), 32'h3);
        $display("test command sweep done");
        // a command with only lane 0 enabled must leave everything alone
        axw(ADDR_COMMAND, {17'h0, 3'h0, idx, 4'h0, 4'h1}, 4'h1, RESP_OKAY);
        axr(ADDR_WORK_DATA, {24'h0, e[15:8]}, RESP_OKAY);
        axr(ADDR_STATUS, {24'h0, e[7:0]}, RESP_OKAY);
        axr(ADDR_COMMAND, 32'h0, RESP_OKAY);
        axw(8'h14, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        axr(8'h14, 32'h0, RESP_SLVERR);
        $display("test refusals done");
        repeat (3) @(posedge core_clk);
        completeRun();
    end
endmodule
